// ==== hdl/tlm_regs.svh ====
// register map, field positions and timing counts of the mode controller
`ifndef TLM_REGS_SVH
`define TLM_REGS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define TLM_CTRL_OFS 8'h00
`define TLM_TXD_OFS 8'h04
`define TLM_STAT_OFS 8'h08

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define TLM_CTRL_NORMAL 0
`define TLM_CTRL_SLOPE_LOW 1
`define TLM_CTRL_SLEEP 2
`define TLM_CTRL_FLASH 3
`define TLM_CTRL_WAKE_B_DIS 4
`define TLM_TXD_A 0
`define TLM_TXD_B 1
`define TLM_STAT_ERR 8
`define TLM_WAKE_SRC_RST 3'h7

// ----------------------------------------------------------------------
// timing, times in ns and counts in cycles of hclk
// ----------------------------------------------------------------------
`define TLM_CLK_NS 8
`define TLM_T_MODE_NS 10000
`define TLM_T_SET_NS 5000
`define TLM_T_REC_NS 10000
`define TLM_FLASH_LOW_TIME_NS 60000
`define TLM_FLASH_EDGE_TIME_A_NS 20000
`define TLM_FLASH_EDGE_TIME_B_NS 20000
`define TLM_FLASH_EDGE_TIME_C_NS 20000
`define TLM_MODE_CYC ((`TLM_T_MODE_NS + `TLM_CLK_NS - 1) / `TLM_CLK_NS)
`define TLM_SET_CYC (`TLM_T_SET_NS / `TLM_CLK_NS)
`define TLM_REC_CYC ((`TLM_T_REC_NS + `TLM_CLK_NS - 1) / `TLM_CLK_NS)
`define TLM_FL1_CYC ((`TLM_FLASH_LOW_TIME_NS + `TLM_CLK_NS - 1) / `TLM_CLK_NS)
`define TLM_FL2_CYC ((`TLM_FLASH_EDGE_TIME_A_NS + `TLM_CLK_NS - 1) / `TLM_CLK_NS)
`define TLM_FL3_CYC ((`TLM_FLASH_EDGE_TIME_B_NS + `TLM_CLK_NS - 1) / `TLM_CLK_NS)
`define TLM_FL4_CYC ((`TLM_FLASH_EDGE_TIME_C_NS + `TLM_CLK_NS - 1) / `TLM_CLK_NS)

`endif

// ==== hdl/tlm_pkg.sv ====
// types shared by the mode controller and its bench
package tlm_pkg;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_MODE_WAIT = 3'b001,
    PH_RELEASE = 3'b010,
    PH_SLEEP_PREP = 3'b011,
    PH_FL_A = 3'b100,
    PH_FL_B = 3'b101,
    PH_FL_C = 3'b110
  } tlm_phase_type;

  typedef enum logic [2:0] {
    DM_SLEEP = 3'b000,
    DM_STANDBY = 3'b001,
    DM_NSLOPE = 3'b010,
    DM_LSLOPE = 3'b011,
    DM_FLASH = 3'b100
  } tlm_mode_type;

  typedef struct packed {
    logic mode_select;
    logic tx_in_a_o;
    logic tx_in_a_oe;
    logic tx_in_b;
    logic bus_b_wake_disable;
  } tlm_pin_out_type;

  typedef struct packed {
    logic rx_out_a;
    logic rx_out_b;
    logic tx_in_a_i;
    logic inhibit_out_a;
    logic inhibit_out_b;
  } tlm_pin_in_type;

endpackage

// ==== hdl/tlm_mode_ctrl.sv ====
// host-side mode controller for a twin single-wire bus transceiver
//
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`include "tlm_regs.svh"

module tlm_mode_ctrl
  import tlm_pkg::*;
#(
  parameter int unsigned MODE_CYC = `TLM_MODE_CYC,
  parameter int unsigned SET_CYC = `TLM_SET_CYC,
  parameter int unsigned REC_CYC = `TLM_REC_CYC,
  parameter int unsigned FL1_CYC = `TLM_FL1_CYC,
  parameter int unsigned FL2_CYC = `TLM_FL2_CYC,
  parameter int unsigned FL3_CYC = `TLM_FL3_CYC,
  parameter int unsigned FL4_CYC = `TLM_FL4_CYC
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire tlm_pin_in_type pin_in,
  output tlm_pin_out_type pin_out
);

  // select must stay low for the whole flash low time, so the last leg
  // stretches when the three edge windows add up to less
  localparam int unsigned FL_SUM = FL2_CYC + FL3_CYC;
  localparam int unsigned FLC_CYC = (FL1_CYC > FL_SUM + FL4_CYC) ? FL1_CYC - FL_SUM : FL4_CYC;

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (MODE_CYC < 2 || MODE_CYC > 65535 || REC_CYC < 1 || REC_CYC > 65535 ||
      FL2_CYC < 1 || FL3_CYC < 1 || FL4_CYC < 1 || FLC_CYC > 65535 ||
      FL2_CYC > 65535 || FL3_CYC > 65535 || SET_CYC >= MODE_CYC)
  begin : g_bad
    $error("tlm_mode_ctrl: timing counts out of range");
  end

  tlm_phase_type phase_r;
  tlm_mode_type mode_r;
  tlm_mode_type tgt_r;
  tlm_mode_type flash_prev_r;
  tlm_pin_out_type pins_r;
  logic [15:0] cnt_r;
  logic flash_sleep_r;
  logic wake_dis_r;
  logic [2:0] wake_src_r;
  logic cmd_err_r;
  logic inh_prev_r;
  logic pend_r;
  logic wr_r;
  logic [7:0] ofs_r;
  logic hready_r;
  logic [31:0] hrdata_r;
  logic cnt_zero;
  logic idle;
  logic active;
  logic ctrl_wr;
  logic txd_wr;
  logic stat_wr;
  logic do_normal;
  logic do_sleep;
  logic do_flash;
  logic refused;
  logic inh_now;
  logic [31:0] rd_val;

  assign hreadyout = hready_r;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign pin_out = pins_r;

  // ----------------------------------------------------------------------
  // ahb-lite slave: one wait state on every transfer
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend_r <= 1'b0;
      hready_r <= 1'b1;
      wr_r <= 1'b0;
      ofs_r <= 8'h00;
    end
    else if (ce)
    begin
      if (pend_r)
      begin
        pend_r <= 1'b0;
        hready_r <= 1'b1;
      end
      else if (hsel && htrans[1] && hready)
      begin
        pend_r <= 1'b1;
        hready_r <= 1'b0;
        wr_r <= hwrite;
        ofs_r <= haddr[7:0];
      end
    end
  end

  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (ofs_r == `TLM_CTRL_OFS)
    begin
      rd_val[`TLM_CTRL_WAKE_B_DIS] = wake_dis_r;
    end
    else if (ofs_r == `TLM_TXD_OFS)
    begin
      rd_val[`TLM_TXD_A] = pins_r.tx_in_a_o;
      rd_val[`TLM_TXD_B] = pins_r.tx_in_b;
    end
    else if (ofs_r == `TLM_STAT_OFS)
    begin
      rd_val[2:0] = phase_r;
      rd_val[6:4] = mode_r;
      rd_val[7] = !idle;
      rd_val[`TLM_STAT_ERR] = cmd_err_r;
      rd_val[11:9] = wake_src_r;
      rd_val[16:12] = pin_in;
    end
  end

  // unmapped offsets read as zero and ignore writes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_r <= 32'h0000_0000;
    end
    else if (ce && pend_r && !wr_r)
    begin
      hrdata_r <= rd_val;
    end
  end

  // ----------------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------------
  assign cnt_zero = (cnt_r == 16'h0000);
  assign idle = (phase_r == PH_IDLE);
  assign active = (mode_r == DM_NSLOPE) || (mode_r == DM_LSLOPE) || (mode_r == DM_FLASH);
  assign ctrl_wr = pend_r && wr_r && (ofs_r == `TLM_CTRL_OFS);
  assign txd_wr = pend_r && wr_r && (ofs_r == `TLM_TXD_OFS);
  assign stat_wr = pend_r && wr_r && (ofs_r == `TLM_STAT_OFS);
  assign do_normal = ctrl_wr && hwdata[`TLM_CTRL_NORMAL] && idle && !active;
  assign do_sleep = ctrl_wr && !hwdata[`TLM_CTRL_NORMAL] && hwdata[`TLM_CTRL_SLEEP] &&
                    idle && active;
  // flash only from a slope mode, or out of flash again
  assign do_flash = ctrl_wr && !hwdata[`TLM_CTRL_NORMAL] && !hwdata[`TLM_CTRL_SLEEP] &&
                    hwdata[`TLM_CTRL_FLASH] && idle && active;
  assign refused = ctrl_wr && |{hwdata[`TLM_CTRL_NORMAL], hwdata[`TLM_CTRL_SLEEP],
                   hwdata[`TLM_CTRL_FLASH]} && !do_normal && !do_sleep && !do_flash;
  assign inh_now = pin_in.inhibit_out_a || pin_in.inhibit_out_b;

  // a refusal in the same cycle as the clearing write stays visible
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmd_err_r <= 1'b0;
    end
    else if (ce)
    begin
      cmd_err_r <= refused || (cmd_err_r && !(stat_wr && hwdata[`TLM_STAT_ERR]));
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wake_dis_r <= 1'b0;
    end
    else if (ce && ctrl_wr)
    begin
      wake_dis_r <= hwdata[`TLM_CTRL_WAKE_B_DIS];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      inh_prev_r <= 1'b0;
    end
    else if (ce)
    begin
      inh_prev_r <= inh_now;
    end
  end

  // ----------------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase_r <= PH_IDLE;
      mode_r <= DM_STANDBY;
      tgt_r <= DM_STANDBY;
      flash_prev_r <= DM_NSLOPE;
      flash_sleep_r <= 1'b0;
      cnt_r <= 16'h0000;
      wake_src_r <= `TLM_WAKE_SRC_RST;
      pins_r <= '0;
    end
    else if (ce)
    begin
      // wake-disable pin follows the write itself, so it is settled before
      // select falls; a flash command waits until select is already low
      pins_r.bus_b_wake_disable <= (ctrl_wr && !do_flash) ? hwdata[`TLM_CTRL_WAKE_B_DIS] :
                                   wake_dis_r;
      if (!cnt_zero)
      begin
        cnt_r <= cnt_r - 16'h0001;
      end
      case (phase_r)
        PH_IDLE:
        begin
          if (do_normal)
          begin
            pins_r.mode_select <= 1'b1;
            pins_r.tx_in_a_oe <= 1'b1;
            pins_r.tx_in_b <= 1'b1;
            cnt_r <= 16'(MODE_CYC - 1);
            phase_r <= PH_MODE_WAIT;
            if (mode_r == DM_SLEEP && flash_sleep_r)
            begin
              // back into flash after sleep from flash
              pins_r.tx_in_a_o <= 1'b1;
              tgt_r <= DM_FLASH;
            end
            else
            begin
              // slope chosen by first transmit level
              pins_r.tx_in_a_o <= !hwdata[`TLM_CTRL_SLOPE_LOW];
              tgt_r <= hwdata[`TLM_CTRL_SLOPE_LOW] ? DM_LSLOPE : DM_NSLOPE;
            end
          end
          else if (do_sleep)
          begin
            // wake-disable level already stable before select falls
            pins_r.tx_in_a_o <= 1'b1;
            pins_r.tx_in_b <= 1'b1;
            flash_sleep_r <= (mode_r == DM_FLASH);
            phase_r <= PH_SLEEP_PREP;
          end
          else if (do_flash)
          begin
            // select low, first transmit still high
            pins_r.mode_select <= 1'b0;
            pins_r.tx_in_a_o <= 1'b1;
            pins_r.tx_in_b <= 1'b1;
            cnt_r <= 16'(FL2_CYC - 1);
            phase_r <= PH_FL_A;
          end
          else if (mode_r == DM_SLEEP && inh_now && !inh_prev_r)
          begin
            // wake seen as inhibit rising; capture first source only
            mode_r <= DM_STANDBY;
            flash_sleep_r <= 1'b0;
            // read receive levels and pulled-down transmit
            if (wake_src_r == `TLM_WAKE_SRC_RST)
            begin
              wake_src_r <= {pin_in.rx_out_a, pin_in.rx_out_b, pin_in.tx_in_a_i};
            end
          end
          else if (txd_wr && active)
          begin
            pins_r.tx_in_a_o <= hwdata[`TLM_TXD_A];
            pins_r.tx_in_b <= hwdata[`TLM_TXD_B];
          end
        end
        PH_MODE_WAIT:
        begin
          // hold slope level until the settle time ends
          if (cnt_zero)
          begin
            mode_r <= tgt_r;
            flash_sleep_r <= 1'b0;
            // device clears its wake flags on entering normal
            wake_src_r <= `TLM_WAKE_SRC_RST;
            pins_r.tx_in_a_o <= 1'b1;
            pins_r.tx_in_b <= 1'b1;
            cnt_r <= 16'(REC_CYC - 1);
            phase_r <= PH_RELEASE;
          end
        end
        PH_RELEASE:
        begin
          // both transmit inputs high until release
          pins_r.tx_in_a_o <= 1'b1;
          pins_r.tx_in_b <= 1'b1;
          if (cnt_zero)
          begin
            phase_r <= PH_IDLE;
          end
        end
        PH_SLEEP_PREP:
        begin
          // select low; stop driving first transmit input, drive second low
          pins_r.mode_select <= 1'b0;
          pins_r.tx_in_a_oe <= 1'b0;
          pins_r.tx_in_a_o <= 1'b0;
          pins_r.tx_in_b <= 1'b0;
          mode_r <= DM_SLEEP;
          phase_r <= PH_IDLE;
        end
        PH_FL_A:
        begin
          if (cnt_zero)
          begin
            pins_r.tx_in_a_o <= 1'b0;
            cnt_r <= 16'(FL3_CYC - 1);
            phase_r <= PH_FL_B;
          end
        end
        PH_FL_B:
        begin
          if (cnt_zero)
          begin
            pins_r.tx_in_a_o <= 1'b1;
            cnt_r <= 16'(FLC_CYC - 1);
            phase_r <= PH_FL_C;
          end
        end
        PH_FL_C:
        begin
          if (cnt_zero)
          begin
            pins_r.mode_select <= 1'b1;
            // leaving flash restores the slope it came from
            if (mode_r == DM_FLASH)
            begin
              mode_r <= flash_prev_r;
            end
            else
            begin
              flash_prev_r <= mode_r;
              mode_r <= DM_FLASH;
            end
            cnt_r <= 16'(REC_CYC - 1);
            phase_r <= PH_RELEASE;
          end
        end
        default:
        begin
          phase_r <= PH_IDLE;
        end
      endcase
    end
  end

endmodule

// ==== tb/tlm_mode_ctrl_sva.sv ====
// port assertions for the mode controller
`timescale 1ns/100ps
module tlm_mode_ctrl_chk
  import tlm_pkg::*;
#(
  parameter int unsigned MODE_CYC = 4,
  parameter int unsigned REC_CYC = 3
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire tlm_pin_out_type pin_out
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire en = pin_out.mode_select;
  wire oe = pin_out.tx_in_a_oe;
  wire ta = pin_out.tx_in_a_o;
  wire tb = pin_out.tx_in_b;
  // cycles since select rose; saturates so it never wraps
  int unsigned up;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      up <= 0;
    else
      up <= !en ? 0 : (up < 999 ? up + 1 : up);
  property p_sel_drive; en |-> oe; endproperty
  a_sel_drive: assert property (p_sel_drive) else $error("select high, line a undriven");
  property p_settle_hold; up != 0 && up < MODE_CYC |-> $stable(ta) && oe; endproperty
  a_settle_hold: assert property (p_settle_hold) else $error("line a moved in settle");
  property p_recessive; en && up < MODE_CYC + REC_CYC - 1 |-> tb; endproperty
  a_recessive: assert property (p_recessive) else $error("line b low in mode change");
  property p_release; en && up > MODE_CYC && up < MODE_CYC + REC_CYC - 1 |-> ta && tb; endproperty
  a_release: assert property (p_release) else $error("release hold broken");
  property p_wake_dis; $fell(en) |-> $stable(pin_out.bus_b_wake_disable); endproperty
  a_wake_dis: assert property (p_wake_dis) else $error("wake disable moved at sleep");
  // flash edges: low for 2 cycles, high for 4, then select returns
  property p_flash_seq;
    $fell(ta) && oe && !en |-> (!ta && !en) [*2] ##1 (ta && !en) [*4] ##1 en;
  endproperty
  a_flash_seq: assert property (p_flash_seq) else $error("flash edge timing wrong");
  property p_sleep_quiet; !en && !oe |-> !tb && !ta; endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("lines driven in sleep");
  property p_sleep_prep; $fell(en) && !oe |-> $past(ta) && $past(tb); endproperty
  a_sleep_prep: assert property (p_sleep_prep) else $error("no recessive before sleep");
endmodule
bind tlm_mode_ctrl tlm_mode_ctrl_chk #(.MODE_CYC(MODE_CYC), .REC_CYC(REC_CYC)) chk_u (
  .hclk(hclk), .hresetn(hresetn), .pin_out(pin_out));

// ==== tb/tlm_dev_model.sv ====
// behavioural twin transceiver as seen from its host pins
`timescale 1ns/100ps
module tlm_dev_model
  import tlm_pkg::*;
#(
  parameter int MODE_CYC = 4,
  parameter int REC_CYC = 3
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire tlm_pin_out_type pin_out,
  input wire logic [1:0] wake_kind,
  output tlm_pin_in_type pin_in,
  output tlm_mode_type mode
);
  tlm_mode_type pre;
  tlm_mode_type slp;
  logic en_q;
  logic txa_q;
  logic fl_pend;
  logic wb_off;
  logic [2:0] src;
  int cnt;
  int rel;
  logic txa;
  logic up;
  // strong pull-down after local wake beats host pull-up
  assign txa = pin_out.tx_in_a_oe ? pin_out.tx_in_a_o : !(mode == DM_STANDBY && !src[0]);
  // transmission blocked until lines held high
  assign up = mode inside {DM_NSLOPE, DM_LSLOPE, DM_FLASH} && rel >= REC_CYC;
  assign pin_in = {mode == DM_STANDBY ? src[2] : (up ? txa : mode != DM_SLEEP),
    mode == DM_STANDBY ? src[1] : (up ? pin_out.tx_in_b : mode != DM_SLEEP),
    txa, mode != DM_SLEEP, mode != DM_SLEEP};
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      mode <= DM_STANDBY;
      pre <= DM_STANDBY;
      slp <= DM_NSLOPE;
      {en_q, txa_q, fl_pend, wb_off, src, cnt, rel} <= '0;
      src <= 3'h7;
    end
    else
    begin
      en_q <= pin_out.mode_select;
      txa_q <= txa;
      rel <= !pin_out.mode_select ? 0 : rel + (txa && pin_out.tx_in_b);
      // falling edge on line a while select low
      if (mode == DM_SLEEP && !pin_out.mode_select && txa_q && !txa)
        fl_pend <= 1'h1;
      if (pin_out.mode_select && !en_q)
      begin
        mode <= DM_STANDBY;
        cnt <= 1;
      end
      // the host lets go of the slope level right as settle ends, so decide one sample early
      else if (cnt == MODE_CYC - 1)
      begin
        cnt <= 0;
        src <= 3'h7;
        fl_pend <= 1'h0;
        if (fl_pend)
          mode <= pre == DM_FLASH ? slp : DM_FLASH;
        else if (pre == DM_FLASH)
          mode <= DM_FLASH;
        else
          mode <= txa ? DM_NSLOPE : DM_LSLOPE;
        if (!fl_pend && pre != DM_FLASH)
          slp <= txa ? DM_NSLOPE : DM_LSLOPE;
      end
      else if (cnt != 0)
        cnt <= cnt + 1;
      if (!pin_out.mode_select && en_q)
      begin
        pre <= mode;
        mode <= DM_SLEEP;
        wb_off <= pin_out.bus_b_wake_disable;
        fl_pend <= 1'h0;
        cnt <= 0;
      end
      if (mode == DM_SLEEP && !pin_out.mode_select && wake_kind != 0 && !(wake_kind == 3 && wb_off))
      begin
        mode <= DM_STANDBY;
        pre <= DM_STANDBY;
        if (src == 3'h7)
          src <= {1'h0, wake_kind != 2'h3, wake_kind != 2'h1};
      end
    end
endmodule

// ==== tb/test_twin_lin_mode_controller.sv ====
// self-checking bench: bus tasks drive the controller against a device model
`timescale 1ns/100ps
`include "tlm_regs.svh"
module test_twin_lin_mode_controller
  import tlm_pkg::*;
;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic ce = 1'h1;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic hresp;
  localparam int unsigned MODE_N = 4;
  localparam int unsigned SET_N = 1;
  localparam int unsigned REC_N = 3;
  localparam int unsigned FL1_N = 8;
  localparam int unsigned FLE_N = 2;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] wake_kind = 2'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic [31:0] rv;
  tlm_pin_in_type pin_in;
  tlm_pin_out_type pin_out;
  tlm_mode_type dev_mode;
  int fails = 0;
  int checks_done = 0;
  initial forever #4 hclk = ~hclk;
  // short counts keep the run brief
  tlm_mode_ctrl #(.MODE_CYC(MODE_N), .SET_CYC(SET_N), .REC_CYC(REC_N), .FL1_CYC(FL1_N),
    .FL2_CYC(FLE_N), .FL3_CYC(FLE_N), .FL4_CYC(FLE_N)) dut_u (.hclk(hclk), .hresetn(hresetn),
    .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out));
  tlm_dev_model #(.MODE_CYC(MODE_N), .REC_CYC(REC_N)) dev_u (.hclk(hclk), .hresetn(hresetn),
    .pin_out(pin_out), .wake_kind(wake_kind), .pin_in(pin_in), .mode(dev_mode));
  task automatic close_out;
    $display("checks %0d, fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic await_ready;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'h1 && n < 20);
    if (n >= 20)
    begin
      fails++;
      close_out();
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= 3'h2;
    await_ready();
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= d;
    await_ready();
    rv = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  // poll busy under a bound
  task automatic cmd(input logic [31:0] d);
    xfer(1'h1, `TLM_CTRL_OFS, d);
    for (int n = 0; n < 40; n++)
    begin
      xfer(1'h0, `TLM_STAT_OFS, 32'h0);
      if (rv[7] === 1'h0)
        return;
    end
    fails++;
    close_out();
  endtask
  task automatic st(input tlm_mode_type m, input logic [2:0] w);
    xfer(1'h0, `TLM_STAT_OFS, 32'h0);
    chk("status", {24'h0, w, 2'h0, m}, {24'h0, rv[11:4]});
    chk("device mode", {29'h0, m}, {29'h0, dev_mode});
    $display("test done: %s", m.name());
  endtask
  task automatic wake(input logic [1:0] k);
    wake_kind <= k;
    @(posedge hclk);
    wake_kind <= 2'h0;
    repeat (4) @(posedge hclk);
  endtask
  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    chk("pins at reset", 32'h0, {27'h0, pin_out});
    st(DM_STANDBY, 3'h7);
    xfer(1'h1, `TLM_CTRL_OFS, 32'h8);
    xfer(1'h0, `TLM_STAT_OFS, 32'h0);
    chk("refused flash", 32'h1, {31'h0, rv[8]});
    xfer(1'h1, `TLM_STAT_OFS, 32'h100);
    xfer(1'h0, 8'h0c, 32'h0);
    chk("unmapped", 32'h0, rv);
    cmd(32'h1);
    st(DM_NSLOPE, 3'h7);
    xfer(1'h1, `TLM_TXD_OFS, 32'h2);
    xfer(1'h0, `TLM_STAT_OFS, 32'h0);
    chk("rx follows tx", 32'h1, {30'h0, rv[16:15]});
    xfer(1'h0, `TLM_TXD_OFS, 32'h0);
    chk("txd readback", 32'h2, rv);
    xfer(1'h1, `TLM_TXD_OFS, 32'h1);
    xfer(1'h0, `TLM_STAT_OFS, 32'h0);
    chk("rx follows tx b", 32'h2, {30'h0, rv[16:15]});
    xfer(1'h1, `TLM_TXD_OFS, 32'h3);
    cmd(32'h14);
    chk("wake disable pin", 32'h1, {31'h0, pin_out.bus_b_wake_disable});
    xfer(1'h0, `TLM_CTRL_OFS, 32'h0);
    chk("wake disable readback", 32'h10, rv);
    st(DM_SLEEP, 3'h7);
    wake(2'h3);
    st(DM_SLEEP, 3'h7);
    wake(2'h1);
    st(DM_STANDBY, 3'h2);
    wake(2'h2);
    st(DM_STANDBY, 3'h2);
    cmd(32'h3);
    st(DM_LSLOPE, 3'h7);
    cmd(32'h4);
    wake(2'h3);
    st(DM_STANDBY, 3'h1);
    cmd(32'h3);
    cmd(32'h8);
    st(DM_FLASH, 3'h7);
    cmd(32'h4);
    st(DM_SLEEP, 3'h7);
    cmd(32'h1);
    st(DM_FLASH, 3'h7);
    cmd(32'h8);
    st(DM_LSLOPE, 3'h7);
    ce <= 1'h0;
    repeat (3) @(posedge hclk);
    ce <= 1'h1;
    st(DM_LSLOPE, 3'h7);
    close_out();
  end
endmodule
